/* File: verilog/tksc_cfg.svh */
`ifndef TKSC_CFG_SVH
`define TKSC_CFG_SVH
// ****************************************
// global register offsets
// ****************************************
`define TKSC_OFF_PRELOAD 8'h00
`define TKSC_OFF_SCAN 8'h01
`define TKSC_OFF_FREQ 8'h02
`define TKSC_OFF_SHR_LO 8'h03
`define TKSC_OFF_SHR_HI 8'h04
`define TKSC_OFF_IRQ 8'h05
// ****************************************
// per-module register block
// ****************************************
`define TKSC_MOD_BASE 8'h10
`define TKSC_MOD_STRIDE 8'h08
`define TKSC_MOFF_CNT_LO 8'h00
`define TKSC_MOFF_CNT_HI 8'h01
`define TKSC_MOFF_TRIM_LO 8'h02
`define TKSC_MOFF_TRIM_HI 8'h03
`define TKSC_MOFF_CTRL0 8'h04
`define TKSC_MOFF_CTRL1 8'h05
`define TKSC_MOFF_CF_LO 8'h06
`define TKSC_MOFF_CF_HI 8'h07
// ****************************************
// field positions
// ****************************************
`define TKSC_B_OVF 6
`define TKSC_B_START 5
`define TKSC_B_CFOV 4
`define TKSC_B_REFOV 3
`define TKSC_B_SHARE 2
`define TKSC_B_IRQ 0
`define TKSC_C0_SOFC 3
`define TKSC_C1_SLOTCLK 7
`define TKSC_C1_ROEN 5
`define TKSC_C1_KOEN 4
`define TKSC_C1_MASK 8'hbf
// ****************************************
// reset values and counts
// ****************************************
`define TKSC_RST_BYTE 8'h00
`define TKSC_RST_FREQ 2'h3
`define TKSC_SLOT_PRE_MAX 5'h1f
`define TKSC_SLOT_TMR_MAX 8'hff
`endif

/* File: verilog/tksc_pkg.sv */
package tksc_pkg;
  typedef struct packed {
    logic [4:0] pre;
    logic [7:0] tmr;
    logic slot_run;
    logic done;
    logic [15:0] cnt;
    logic [15:0] cf;
    logic [9:0] trim;
    logic [7:0] c0;
    logic [7:0] c1;
    logic [3:0] key_prev;
    logic ref_prev;
    logic [2:0] hop;
    logic [3:0] key_en;
    logic ref_en;
  } tksc_mod_t;

  typedef struct packed {
    logic [7:0] preload;
    logic start;
    logic running;
    logic ovf;
    logic cf_ovf;
    logic ref_ovf;
    logic share;
    logic [1:0] div_sel;
    logic [1:0] freq;
    logic [15:0] shr;
    logic irq;
    logic [2:0] div;
    logic [7:0] rdata;
  } tksc_glb_t;
endpackage

/* File: verilog/tksc_top.sv */
`timescale 1ns/1ns
`include "tksc_cfg.svh"
// Function
// - independent modules, four keys each, own oscillators, control and registers.
// - per-key register bit picks touch or plain I/O use of the pad.
// - 8-bit preload; overflow after (256 - preload) * 32 slot clock ticks.
// - selected slot overflow sets slot overflow flag and interrupt request flag.
// - slot overflow stops all key and reference oscillators automatically.
// - slot overflow switches off all module counters and slot timers.
// - start bit zero clears C/F, 16-bit and 5-bit counters, not 8-bit timer.
// - start bit rising switches on counters and gates oscillator clocks in.
// - C/F counter overflow sets sticky flag, cleared only by writing zero.
// - 16-bit counter overflow sets sticky flag, cleared only by writing zero.
// - sharing bit 0 uses own slot counters, 1 uses module 0 counter.
// - 2-bit field picks 16-bit counter clock: sys, /2, /4, /8.
// - 2-bit oscillator frequency field, reset 11, selects 500 to 2000 kHz.
// - shared 16-bit counter read as low and high bytes, reset zero.
// - each module exposes own 16-bit counter as low and high bytes.
// - each module holds 10-bit reference trim over low byte and 2-bit high.
// - per-module key and reference oscillator enables plus per-key pin select.
// - first control register holds 2-bit key selector for measurement counter.
// - unimplemented bit 6 of the second control register reads as zero; the first control register reads back all 8 bits.
// - key selector 00..11 selects first to fourth key of the module.
// - slot clock select: 0 reference oscillator, 1 system clock divided by four.
// - hopping bit 1 means hardware hopping, 0 means 3-bit software field.
module tksc_top
  import tksc_pkg::*;
#(
  parameter int NUM_MOD = 5
)(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [4*NUM_MOD-1:0] key_osc_in,
  input wire logic [NUM_MOD-1:0] ref_osc_in,
  output logic [4*NUM_MOD-1:0] key_osc_en,
  output logic [NUM_MOD-1:0] ref_osc_en,
  output logic [4*NUM_MOD-1:0] key_pin_touch,
  output logic [2*NUM_MOD-1:0] key_mux_sel,
  output logic [10*NUM_MOD-1:0] ref_trim,
  output logic [3*NUM_MOD-1:0] hop_code,
  output logic [1:0] osc_freq_sel,
  output logic touch_interrupt_request
);

  typedef struct packed {
    tksc_glb_t g;
    tksc_mod_t [NUM_MOD-1:0] m;
  } tksc_state_t;

  tksc_state_t st_r;
  tksc_state_t st_nxt;

  logic cnt_en;
  logic div4_en;
  logic scan_wr;
  logic start_rise;
  logic slot_evt;
  logic all_done;
  logic tick;
  logic key_rise;
  logic [16:0] sum;
  logic [7:0] rd;
  logic [7:0] base;

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    st_nxt = st_r;
    rd = 8'h00;
    tick = 1'b0;
    key_rise = 1'b0;
    sum = 17'h0;
    base = 8'h00;
    st_nxt.g.div = st_r.g.div + 3'h1;
    unique case (st_r.g.div_sel)
      2'h0: cnt_en = 1'b1;
      2'h1: cnt_en = st_r.g.div[0];
      2'h2: cnt_en = &st_r.g.div[1:0];
      2'h3: cnt_en = &st_r.g.div;
    endcase
    div4_en = &st_r.g.div[1:0];
    scan_wr = reg_wr && (reg_addr == `TKSC_OFF_SCAN);
    start_rise = scan_wr && reg_wdata[`TKSC_B_START] && !st_r.g.start;

    // software writes; flag clears come first so that a hardware set wins
    if (reg_wr)
    begin
      if (reg_addr == `TKSC_OFF_PRELOAD)
        st_nxt.g.preload = reg_wdata;
      if (scan_wr)
      begin
        st_nxt.g.start = reg_wdata[`TKSC_B_START];
        st_nxt.g.ovf = st_r.g.ovf & reg_wdata[`TKSC_B_OVF];
        st_nxt.g.cf_ovf = st_r.g.cf_ovf & reg_wdata[`TKSC_B_CFOV];
        st_nxt.g.ref_ovf = st_r.g.ref_ovf & reg_wdata[`TKSC_B_REFOV];
        st_nxt.g.share = reg_wdata[`TKSC_B_SHARE];
        st_nxt.g.div_sel = reg_wdata[1:0];
      end
      if (reg_addr == `TKSC_OFF_FREQ)
        st_nxt.g.freq = reg_wdata[1:0];
      if (reg_addr == `TKSC_OFF_IRQ)
        st_nxt.g.irq = st_r.g.irq & reg_wdata[`TKSC_B_IRQ];
      for (int m = 0; m < NUM_MOD; m++)
      begin
        base = 8'(`TKSC_MOD_BASE + m * `TKSC_MOD_STRIDE);
        if (reg_addr == base + `TKSC_MOFF_TRIM_LO)
          st_nxt.m[m].trim[7:0] = reg_wdata;
        if (reg_addr == base + `TKSC_MOFF_TRIM_HI)
          st_nxt.m[m].trim[9:8] = reg_wdata[1:0];
        if (reg_addr == base + `TKSC_MOFF_CTRL0)
          st_nxt.m[m].c0 = reg_wdata;
        if (reg_addr == base + `TKSC_MOFF_CTRL1)
          st_nxt.m[m].c1 = reg_wdata & `TKSC_C1_MASK;
      end
    end

    if (!st_nxt.g.start)
    begin
      // the 8-bit timer keeps its value; only a start reloads it
      st_nxt.g.running = 1'b0;
      st_nxt.g.shr = 16'h0000;
      for (int m = 0; m < NUM_MOD; m++)
      begin
        st_nxt.m[m].cnt = 16'h0000;
        st_nxt.m[m].cf = 16'h0000;
        st_nxt.m[m].pre = 5'h00;
        st_nxt.m[m].slot_run = 1'b0;
      end
    end
    else if (start_rise)
    begin
      st_nxt.g.running = 1'b1;
      for (int m = 0; m < NUM_MOD; m++)
      begin
        st_nxt.m[m].slot_run = 1'b1;
        st_nxt.m[m].done = 1'b0;
        st_nxt.m[m].pre = 5'h00;
        st_nxt.m[m].tmr = st_r.g.preload;
        if (st_r.m[m].c0[`TKSC_C0_SOFC])
          st_nxt.m[m].hop = st_r.m[m].hop + 3'h1;
      end
    end
    else if (st_r.g.running)
    begin
      if (cnt_en)
      begin
        sum = {1'b0, st_r.g.shr} + 17'h1;
        st_nxt.g.shr = sum[15:0];
        if (sum[16])
          st_nxt.g.ref_ovf = 1'b1;
      end
      for (int m = 0; m < NUM_MOD; m++)
      begin
        // slot clock: reference oscillator edge or system clock / 4
        if (st_r.m[m].c1[`TKSC_C1_SLOTCLK])
          tick = div4_en;
        else
          tick = ref_osc_in[m] && !st_r.m[m].ref_prev;
        if (tick && st_r.m[m].slot_run)
        begin
          st_nxt.m[m].pre = st_r.m[m].pre + 5'h01;
          if (st_r.m[m].pre == `TKSC_SLOT_PRE_MAX)
          begin
            st_nxt.m[m].tmr = st_r.m[m].tmr + 8'h01;
            if (st_r.m[m].tmr == `TKSC_SLOT_TMR_MAX)
            begin
              st_nxt.m[m].done = 1'b1;
              st_nxt.m[m].slot_run = 1'b0;
            end
          end
        end
        if (cnt_en)
        begin
          sum = {1'b0, st_r.m[m].cnt} + 17'h1;
          st_nxt.m[m].cnt = sum[15:0];
          if (sum[16])
            st_nxt.g.ref_ovf = 1'b1;
        end
        key_rise = key_osc_in[4*m + int'(st_r.m[m].c0[7:6])]
          && !st_r.m[m].key_prev[st_r.m[m].c0[7:6]];
        if (key_rise && st_r.m[m].c1[`TKSC_C1_KOEN])
        begin
          sum = {1'b0, st_r.m[m].cf} + 17'h1;
          st_nxt.m[m].cf = sum[15:0];
          if (sum[16])
            st_nxt.g.cf_ovf = 1'b1;
        end
      end
    end

    all_done = 1'b1;
    for (int m = 0; m < NUM_MOD; m++)
      all_done = all_done & st_nxt.m[m].done;
    slot_evt = st_r.g.running && st_nxt.g.running
      && (st_r.g.share ? st_nxt.m[0].done : all_done);
    if (slot_evt)
    begin
      st_nxt.g.running = 1'b0;
      st_nxt.g.ovf = 1'b1;
      st_nxt.g.irq = 1'b1;
      for (int m = 0; m < NUM_MOD; m++)
        st_nxt.m[m].slot_run = 1'b0;
    end

    for (int m = 0; m < NUM_MOD; m++)
    begin
      st_nxt.m[m].key_prev = key_osc_in[4*m +: 4];
      st_nxt.m[m].ref_prev = ref_osc_in[m];
      // oscillators run only inside a scan
      st_nxt.m[m].key_en = {4{st_nxt.g.running && st_nxt.m[m].c1[`TKSC_C1_KOEN]}}
        & st_nxt.m[m].c1[3:0];
      st_nxt.m[m].ref_en = st_nxt.g.running && st_nxt.m[m].c1[`TKSC_C1_ROEN];
      // software code copied while hardware hopping is off, so the pin stays a plain flop
      // hardware hopping then starts from the last software code
      if (!st_nxt.m[m].c0[`TKSC_C0_SOFC])
        st_nxt.m[m].hop = st_nxt.m[m].c0[2:0];
    end

    // read mux, unmapped addresses answer zero
    if (reg_addr == `TKSC_OFF_PRELOAD)
      rd = st_r.g.preload;
    if (reg_addr == `TKSC_OFF_SCAN)
      rd = {1'b0, st_r.g.ovf, st_r.g.start, st_r.g.cf_ovf, st_r.g.ref_ovf,
            st_r.g.share, st_r.g.div_sel};
    if (reg_addr == `TKSC_OFF_FREQ)
      rd = {6'h00, st_r.g.freq};
    if (reg_addr == `TKSC_OFF_SHR_LO)
      rd = st_r.g.shr[7:0];
    if (reg_addr == `TKSC_OFF_SHR_HI)
      rd = st_r.g.shr[15:8];
    if (reg_addr == `TKSC_OFF_IRQ)
      rd = {7'h00, st_r.g.irq};
    for (int m = 0; m < NUM_MOD; m++)
    begin
      base = 8'(`TKSC_MOD_BASE + m * `TKSC_MOD_STRIDE);
      if (reg_addr == base + `TKSC_MOFF_CNT_LO)
        rd = st_r.m[m].cnt[7:0];
      if (reg_addr == base + `TKSC_MOFF_CNT_HI)
        rd = st_r.m[m].cnt[15:8];
      if (reg_addr == base + `TKSC_MOFF_TRIM_LO)
        rd = st_r.m[m].trim[7:0];
      if (reg_addr == base + `TKSC_MOFF_TRIM_HI)
        rd = {6'h00, st_r.m[m].trim[9:8]};
      if (reg_addr == base + `TKSC_MOFF_CTRL0)
        rd = st_r.m[m].c0;
      if (reg_addr == base + `TKSC_MOFF_CTRL1)
        rd = st_r.m[m].c1;
      if (reg_addr == base + `TKSC_MOFF_CF_LO)
        rd = st_r.m[m].cf[7:0];
      if (reg_addr == base + `TKSC_MOFF_CF_HI)
        rd = st_r.m[m].cf[15:8];
    end
    st_nxt.g.rdata = reg_rd ? rd : 8'h00;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_r <= '0;
      st_r.g.freq <= `TKSC_RST_FREQ;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata = st_r.g.rdata;
  assign osc_freq_sel = st_r.g.freq;
  assign touch_interrupt_request = st_r.g.irq;

  generate
    for (genvar m = 0; m < NUM_MOD; m++)
    begin : g_mod
      assign key_osc_en[4*m +: 4] = st_r.m[m].key_en;
      assign ref_osc_en[m] = st_r.m[m].ref_en;
      assign key_pin_touch[4*m +: 4] = st_r.m[m].c1[3:0];
      assign key_mux_sel[2*m +: 2] = st_r.m[m].c0[7:6];
      assign ref_trim[10*m +: 10] = st_r.m[m].trim;
      assign hop_code[3*m +: 3] = st_r.m[m].hop;
    end
  endgenerate

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_ovf_irq;
    $rose(st_r.g.ovf) |-> st_r.g.irq && !st_r.g.running;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("slot overflow without irq");

  property p_osc_stop;
    $rose(st_r.g.ovf) |-> (key_osc_en == '0) && (ref_osc_en == '0);
  endproperty
  a_osc_stop: assert property (p_osc_stop) else $error("oscillators still on after overflow");

  property p_clear;
    !st_r.g.start |-> (st_r.g.shr == 16'h0000) && (st_r.m[0].cnt == 16'h0000) && (st_r.m[0].cf == 16'h0000);
  endproperty
  a_clear: assert property (p_clear) else $error("counters not cleared while stopped");

  property p_start;
    $rose(st_r.g.start) |-> st_r.g.running && st_r.m[0].slot_run;
  endproperty
  a_start: assert property (p_start) else $error("start did not run scan");

  property p_cf_sticky;
    st_r.g.cf_ovf && !(scan_wr && !reg_wdata[`TKSC_B_CFOV]) |=> st_r.g.cf_ovf;
  endproperty
  a_cf_sticky: assert property (p_cf_sticky) else $error("cf overflow flag lost");

  property p_ref_sticky;
    st_r.g.ref_ovf && !(scan_wr && !reg_wdata[`TKSC_B_REFOV]) |=> st_r.g.ref_ovf;
  endproperty
  a_ref_sticky: assert property (p_ref_sticky) else $error("ref overflow flag lost");

  property p_irq_hold;
    st_r.g.irq && !(reg_wr && reg_addr == `TKSC_OFF_IRQ && !reg_wdata[0]) |=> st_r.g.irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");

  property p_trim_hi;
    reg_rd && reg_addr == (`TKSC_MOD_BASE + `TKSC_MOFF_TRIM_HI) |=> reg_rdata[7:2] == 6'h00;
  endproperty
  a_trim_hi: assert property (p_trim_hi) else $error("unimplemented bits read nonzero");

  property p_share;
    st_r.g.running && st_r.g.share && !st_r.m[0].done && st_nxt.m[0].done |=> st_r.g.ovf && !st_r.g.running;
  endproperty
  a_share: assert property (p_share) else $error("shared slot overflow missed");

  property p_freq_rst;
    reset |=> osc_freq_sel == 2'h3;
  endproperty
  a_freq_rst: assert property (disable iff (1'b0) p_freq_rst) else $error("freq reset wrong");

  // module 1 still mid-prescale, so without sharing the scan must go on
  property p_own_slot;
    st_r.g.running && !st_r.g.share && st_r.m[1].slot_run && (st_r.m[1].pre != 5'h1f) && st_nxt.g.start
      |=> st_r.g.running;
  endproperty
  a_own_slot: assert property (p_own_slot) else $error("scan ended while module 1 still timing");

  property p_tmr_keep;
    scan_wr && !reg_wdata[`TKSC_B_START] |=> st_r.m[0].tmr == $past(st_r.m[0].tmr);
  endproperty
  a_tmr_keep: assert property (p_tmr_keep) else $error("slot timer cleared by stop");

  property p_cnt_step;
    st_r.g.running && st_nxt.g.start && (st_r.g.div_sel == 2'h0) |=> st_r.m[0].cnt == $past(st_r.m[0].cnt) + 16'h1;
  endproperty
  a_cnt_step: assert property (p_cnt_step) else $error("module counter missed a system clock");

  c_ovf: cover property ($rose(st_r.g.ovf));
  c_cf: cover property ($rose(st_r.g.cf_ovf));
  c_share: cover property (st_r.g.share && $rose(st_r.g.ovf));
  c_own: cover property (!st_r.g.share && $rose(st_r.g.ovf));

endmodule // tksc_top

/* File: dv/tksc_osc_model.sv */
`timescale 1ns/1ns
// ****************************************
// electrode oscillators, period 2*half mclk
// ****************************************
module tksc_osc_model
  import tksc_pkg::*;
#(
  parameter int NUM_MOD = 5
)(
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] half,
  input wire logic [4*NUM_MOD-1:0] key_osc_en,
  input wire logic [NUM_MOD-1:0] ref_osc_en,
  output logic [4*NUM_MOD-1:0] key_osc_in,
  output logic [NUM_MOD-1:0] ref_osc_in
);
  logic [3:0] tick_r;
  logic flip;
  assign flip = (tick_r == 4'h0);
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      tick_r <= 4'h0;
      key_osc_in <= '0;
      ref_osc_in <= '0;
    end
    else
    begin
      tick_r <= (tick_r + 4'h1 >= half) ? 4'h0 : tick_r + 4'h1;
      // a stopped oscillator rests low at once, never holds a stale high
      key_osc_in <= (flip ? ~key_osc_in : key_osc_in) & key_osc_en;
      ref_osc_in <= (flip ? ~ref_osc_in : ref_osc_in) & ref_osc_en;
    end
  end
endmodule // tksc_osc_model

/* File: dv/test_touch_key_scan_control.sv */
`timescale 1ns/1ns
`include "tksc_cfg.svh"
module test_touch_key_scan_control
  import tksc_pkg::*;
;
  logic mclk, reset, reg_wr, reg_rd, touch_interrupt_request;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, a, b;
  logic [19:0] key_osc_in, key_osc_en, key_pin_touch;
  logic [4:0] ref_osc_in, ref_osc_en;
  logic [9:0] key_mux_sel;
  logic [49:0] ref_trim;
  logic [14:0] hop_code;
  logic [1:0] osc_freq_sel;
  logic [3:0] half;
  int fail_count, tests_run, n;
  localparam logic [7:0] RST_A [8] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h10, 8'h11, 8'h33};

  tksc_top #(.NUM_MOD(5)) dut_u (.mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .key_osc_in(key_osc_in), .ref_osc_in(ref_osc_in),
    .key_osc_en(key_osc_en), .ref_osc_en(ref_osc_en), .key_pin_touch(key_pin_touch), .key_mux_sel(key_mux_sel),
    .ref_trim(ref_trim), .hop_code(hop_code), .osc_freq_sel(osc_freq_sel),
    .touch_interrupt_request(touch_interrupt_request));
  tksc_osc_model #(.NUM_MOD(5)) osc_u (.mclk(mclk), .reset(reset), .half(half), .key_osc_en(key_osc_en),
    .ref_osc_en(ref_osc_en), .key_osc_in(key_osc_in), .ref_osc_in(ref_osc_in));

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ****************************************
  // bus and checking helpers
  // ****************************************
  function automatic logic [7:0] ma(input int m, input logic [7:0] o);
    return `TKSC_MOD_BASE + `TKSC_MOD_STRIDE * m[7:0] + o;
  endfunction
  task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task wr(input logic [7:0] ad, input logic [7:0] wd);
    @(posedge mclk);
    reg_addr <= ad;
    reg_wdata <= wd;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] ad, output logic [7:0] rv);
    @(posedge mclk);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  // start a scan and count mclk cycles until the request flag rises
  task run_scan(input logic sh, input logic [1:0] dv);
    wr(`TKSC_OFF_IRQ, 8'h00);
    wr(`TKSC_OFF_SCAN, {5'h0, sh, dv});
    wr(`TKSC_OFF_SCAN, {5'h4, sh, dv});
    n = 0;
    @(posedge mclk);
    #1 chk("ref osc running", 1'b1, ref_osc_en[0]);
    while (touch_interrupt_request !== 1'b1 && n < 90000)
    begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 90000)
    begin
      chk("scan end", 1'b1, 1'b0);
      give_verdict();
    end
    else
      chk("osc stopped", 25'h0, {key_osc_en, ref_osc_en});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task t_reset;
    rd(`TKSC_OFF_FREQ, d);
    chk("freq reset", 8'h03, d);
    chk("freq pin reset", 2'h3, osc_freq_sel);
    foreach (RST_A[i])
    begin
      rd(RST_A[i], d);
      chk("reset byte", 8'h00, d);
    end
  endtask
  task t_regs;
    wr(`TKSC_OFF_PRELOAD, 8'ha5);
    rd(`TKSC_OFF_PRELOAD, d);
    chk("preload", 8'ha5, d);
    wr(`TKSC_OFF_FREQ, 8'h00);
    rd(`TKSC_OFF_FREQ, d);
    chk("freq pin", 2'h0, osc_freq_sel);
    wr(`TKSC_OFF_FREQ, 8'hff);
    rd(`TKSC_OFF_FREQ, d);
    chk("freq unused bits", 8'h03, d);
    wr(ma(4, 2), 8'ha5);
    wr(ma(4, 3), 8'hff);
    rd(ma(4, 3), d);
    chk("trim high", 8'h03, d);
    chk("trim pins", 10'h3a5, ref_trim[49:40]);
    wr(ma(1, 5), 8'hff);
    rd(ma(1, 5), d);
    chk("ctrl1 unused bit", 8'hbf, d);
    chk("pin function", 4'hf, key_pin_touch[7:4]);
    wr(ma(2, 4), 8'hc5);
    rd(ma(2, 4), d);
    chk("key select", 2'h3, key_mux_sel[5:4]);
    chk("soft hop", 3'h5, hop_code[8:6]);
    rd(8'hff, d);
    chk("unmapped", 8'h00, d);
  endtask
  task t_scan;
    half <= 4'h1;
    wr(`TKSC_OFF_PRELOAD, 8'hff);
    for (int m = 0; m < 5; m++)
    begin
      wr(ma(m, 5), 8'hb4);
      wr(ma(m, 4), (m == 0) ? 8'h80 : 8'h00);
    end
    run_scan(1'b1, 2'h0);
    chk("slot length", 1'b1, n >= 124 && n <= 136);
    rd(`TKSC_OFF_SCAN, d);
    chk("slot ovf flag", 1'b1, d[6]);
    rd(ma(0, 0), a);
    repeat (5) @(posedge mclk);
    rd(ma(0, 0), b);
    chk("count frozen", a, b);
    chk("count span", 1'b1, a >= n - 6 && a <= n + 2);
    rd(`TKSC_OFF_SHR_LO, d);
    chk("shared count", 1'b1, d >= n - 6 && d <= n + 2);
    rd(ma(0, 6), a);
    chk("cf selected key", 1'b1, a >= 8'd50 && a <= 8'd70);
    rd(ma(1, 6), b);
    chk("cf idle key", 8'h00, b);
    repeat (20) @(posedge mclk);
    #1 chk("irq sticky", 1'b1, touch_interrupt_request);
    wr(`TKSC_OFF_IRQ, 8'h00);
    #1 chk("irq cleared", 1'b0, touch_interrupt_request);
    wr(`TKSC_OFF_SCAN, 8'h00);
    rd(ma(0, 0), a);
    rd(ma(0, 6), b);
    chk("cleared counts", 16'h0, {a, b});
  endtask
  task t_div;
    for (int dv = 0; dv < 4; dv++)
    begin
      run_scan(1'b1, dv[1:0]);
      rd(ma(2, 0), a);
      chk("divided count", 1'b1, int'(a) >= (n >> dv) - 4 && int'(a) <= (n >> dv) + 2);
    end
  endtask
  task t_share;
    half <= 4'h4;
    wr(ma(1, 5), 8'h34);
    wr(ma(3, 4), 8'h08);
    run_scan(1'b1, 2'h0);
    chk("shared slot", 1'b1, n >= 124 && n <= 136);
    run_scan(1'b0, 2'h0);
    // 32 ticks of an 8-cycle oscillator; the first tick may come at once
    chk("own slots", 1'b1, n >= 240 && n <= 280);
    chk("hw hop", 3'h2, hop_code[11:9]);
  endtask
  task t_refov;
    half <= 4'h5;
    wr(`TKSC_OFF_PRELOAD, 8'h00);
    wr(ma(0, 5), 8'h34);
    run_scan(1'b1, 2'h0);
    rd(`TKSC_OFF_SCAN, d);
    chk("ref ovf set", 1'b1, d[3]);
    chk("cf ovf clear", 1'b0, d[4]);
    wr(`TKSC_OFF_SCAN, 8'h08);
    rd(`TKSC_OFF_SCAN, d);
    chk("ref ovf kept", 1'b1, d[3]);
    wr(`TKSC_OFF_SCAN, 8'h00);
    rd(`TKSC_OFF_SCAN, d);
    chk("ref ovf cleared", 1'b0, d[3]);
  endtask

  initial
  begin
    reset = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    half = 4'h1;
    fail_count = 0;
    tests_run = 0;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    t_reset();
    t_regs();
    t_scan();
    t_div();
    t_share();
    t_refov();
    give_verdict();
  end
endmodule // test_touch_key_scan_control
